// ===== core/famd_compare.sv
// compares a fetch address against both compare registers
// assumes all inputs are stable within a clock cycle
module famd_compare #(
	parameter int ADDR_W = famd_pkg::ADDR_W
) (
	// operands
	input  wire logic [ADDR_W-1:0] fetch_addr,
	input  wire logic [ADDR_W-1:0] cmp0,
	input  wire logic [ADDR_W-1:0] cmp1,
	input  wire logic [1:0]        cond,
	// results
	output logic                   hit,
	output logic                   hit_by1
);
	// ------------------------------------------------------------
	// unsigned comparison over the full bank and pc width
	// ------------------------------------------------------------
	logic eq0;
	logic eq1;
	logic below0;
	logic above1;

	// raw comparisons
	always_comb begin
		eq0    = (fetch_addr == cmp0);
		eq1    = (fetch_addr == cmp1);
		below0 = (fetch_addr < cmp0);
		above1 = (fetch_addr > cmp1);
	end

	// condition select
	always_comb begin
		hit_by1 = 1'b0;
		case (cond)
			famd_pkg::COND_MATCH0:   hit = eq0;
			famd_pkg::COND_MATCH1:   hit = eq1;
			famd_pkg::COND_MATCH_EI: begin
				hit     = eq0 | eq1;
				hit_by1 = eq1 & ~eq0;
			end
			famd_pkg::COND_OUT_AREA: hit = below0 | above1;
			default:                 hit = 1'b0;
		endcase
	end
endmodule // famd_compare

// ===== core/famd_detector.sv
// top of the fetch address match detector
// assumes the cpu holds a fetch until fetch_ready and accepts the push frame
// in the cycle push_valid is high; control bits come from software as levels

// Functional notes
// - compare every fetch address, request on condition
// - detection takes nmi, fetched instruction skipped
// - select field picks condition; 0 and 1 match compare 0 and compare 1
// - condition two fires on either register
// - out-of-area: below cmp0 or above cmp1
// - requests only while detect enable set
// - compare access ignored while access disabled
// - decision bit tells which register matched under condition two; it holds its value in the other conditions
// - push bank, pc and status of match
module famd_detector (
	// clock and reset
	input  wire logic                       ref_clk,
	input  wire logic                       rst,
	// control bits from software
	input  wire logic                       detect_en,
	input  wire logic [1:0]                 cond_sel,
	input  wire logic                       cmp_access_en,
	// compare register access
	input  wire famd_pkg::famd_cmp_acc_type cmp_acc,
	output logic [famd_pkg::ADDR_W-1:0]     cmp_rdata,
	// fetch path
	input  wire famd_pkg::famd_fetch_type   fetch,
	input  wire logic [15:0]                processor_status_word,
	output logic                            fetch_ready,
	output logic                            fetch_suppress,
	// interrupt entry
	output logic                            nmi_req,
	output logic                            push_valid,
	output famd_pkg::famd_frame_type        push_frame,
	// status
	output logic                            match_by1
);
	localparam int AW = famd_pkg::ADDR_W;

	// ------------------------------------------------------------
	// compare registers
	// ------------------------------------------------------------
	logic [AW-1:0] cmp_q [2];
	logic [AW-1:0] cmp_d [2];
	logic [AW-1:0] rdata_q;
	logic [AW-1:0] rdata_d;

	// writes and reads gated by the access enable
	always_comb begin
		cmp_d   = cmp_q;
		rdata_d = rdata_q;
		if (cmp_access_en && cmp_acc.wr) begin
			cmp_d[cmp_acc.sel] = cmp_acc.wdata;
		end
		if (cmp_access_en && cmp_acc.rd) begin
			rdata_d = cmp_q[cmp_acc.sel];
		end
	end

	// register stage
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cmp_q[0] <= famd_pkg::CMP_RST;
			cmp_q[1] <= famd_pkg::CMP_RST;
			rdata_q  <= famd_pkg::CMP_RST;
		end else begin
			cmp_q   <= cmp_d;
			rdata_q <= rdata_d;
		end
	end

	assign cmp_rdata = rdata_q;

	// ------------------------------------------------------------
	// comparison
	// ------------------------------------------------------------
	logic [AW-1:0] fetch_addr;
	logic          hit;
	logic          hit_by1;

	assign fetch_addr = {fetch.bank, fetch.pc};

	famd_compare #(
		.ADDR_W     (AW)
	) u_compare (
		.fetch_addr (fetch_addr),
		.cmp0       (cmp_q[0]),
		.cmp1       (cmp_q[1]),
		.cond       (cond_sel),
		.hit        (hit),
		.hit_by1    (hit_by1)
	);

	// ------------------------------------------------------------
	// detection sequencer
	// ------------------------------------------------------------
	famd_pkg::famd_state_type st_q;
	famd_pkg::famd_state_type st_d;
	famd_pkg::famd_frame_type frame_q;
	famd_pkg::famd_frame_type frame_d;
	logic                     by1_q;
	logic                     by1_d;
	logic                     detect;

	// a fetch that meets the condition while enabled
	assign detect = fetch.valid && hit && detect_en && (st_q == famd_pkg::ST_IDLE);

	// next state
	always_comb begin
		st_d    = st_q;
		frame_d = frame_q;
		by1_d   = by1_q;
		case (st_q)
			famd_pkg::ST_IDLE: begin
				if (detect) begin
					st_d    = famd_pkg::ST_PUSH;
					frame_d = '{bank: fetch.bank, pc: fetch.pc,
						psw: processor_status_word};
					if (cond_sel == famd_pkg::COND_MATCH_EI) begin
						by1_d = hit_by1;
					end
				end
			end
			famd_pkg::ST_PUSH: st_d = famd_pkg::ST_VECT;
			famd_pkg::ST_VECT: st_d = famd_pkg::ST_IDLE;
			default:           st_d = famd_pkg::ST_IDLE;
		endcase
	end

	// register stage
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_q    <= famd_pkg::ST_IDLE;
			frame_q <= '0;
			by1_q   <= 1'b0;
		end else begin
			st_q    <= st_d;
			frame_q <= frame_d;
			by1_q   <= by1_d;
		end
	end

	// fetch is held off while an entry is in flight, and dropped on detect
	assign fetch_ready    = (st_q == famd_pkg::ST_IDLE);
	assign fetch_suppress = detect;
	assign nmi_req        = (st_q == famd_pkg::ST_PUSH);
	assign push_valid     = (st_q == famd_pkg::ST_PUSH);
	assign push_frame     = frame_q;
	assign match_by1      = by1_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_detect;
		fetch.valid && hit && detect_en && fetch_ready;
	endsequence

	sequence s_entry;
		##1 (nmi_req && push_valid) ##1 (!nmi_req && !fetch_ready) ##1 fetch_ready;
	endsequence

	a_detect_entry: assert property (@(posedge ref_clk) disable iff (rst)
		s_detect |-> s_entry)
		else $error("detection did not enter interrupt");
	a_req_cause: assert property (@(posedge ref_clk) disable iff (rst)
		nmi_req |-> ($past(fetch.valid) && $past(hit)))
		else $error("request raised without a matching fetch");
	a_skip_fetch: assert property (@(posedge ref_clk) disable iff (rst)
		s_detect |-> fetch_suppress ##1 (!fetch_suppress && !fetch_ready))
		else $error("matched instruction not held off");
	a_no_req_off: assert property (@(posedge ref_clk) disable iff (rst)
		nmi_req |-> $past(detect_en))
		else $error("request raised while detect disabled");
	a_off_quiet: assert property (@(posedge ref_clk) disable iff (rst)
		!detect_en |-> !fetch_suppress)
		else $error("fetch suppressed while detect disabled");
	a_cond0_eq: assert property (@(posedge ref_clk) disable iff (rst)
		(cond_sel == 2'h0 && fetch_ready && fetch.valid && detect_en &&
		fetch_addr == cmp_q[0]) |=> nmi_req)
		else $error("condition zero missed");
	a_cond1_eq: assert property (@(posedge ref_clk) disable iff (rst)
		(cond_sel == 2'h1 && fetch_ready && fetch.valid && detect_en &&
		fetch_addr == cmp_q[1]) |=> nmi_req)
		else $error("condition one missed");
	a_either_eq: assert property (@(posedge ref_clk) disable iff (rst)
		(cond_sel == 2'h2 && fetch_ready && fetch.valid && detect_en &&
		fetch_addr == cmp_q[1]) |=> nmi_req)
		else $error("either condition missed on compare 1");
	a_out_area: assert property (@(posedge ref_clk) disable iff (rst)
		(cond_sel == 2'h3 && fetch_ready && fetch.valid && detect_en &&
		fetch_addr < cmp_q[0]) |=> nmi_req)
		else $error("out-of-area below compare 0 missed");
	a_above_area: assert property (@(posedge ref_clk) disable iff (rst)
		(cond_sel == 2'h3 && fetch_ready && fetch.valid && detect_en &&
		fetch_addr > cmp_q[1]) |=> nmi_req)
		else $error("out-of-area above compare 1 missed");
	a_cmp_locked: assert property (@(posedge ref_clk) disable iff (rst)
		!cmp_access_en |=> (cmp_q[0] == $past(cmp_q[0]) && cmp_q[1] == $past(cmp_q[1])
		&& cmp_rdata == $past(cmp_rdata)))
		else $error("compare register changed while locked");
	a_wr_lands: assert property (@(posedge ref_clk) disable iff (rst)
		(cmp_access_en && cmp_acc.wr && !cmp_acc.sel) |=>
		(cmp_q[0] == $past(cmp_acc.wdata)))
		else $error("permitted write to compare 0 lost");
	a_rd_return: assert property (@(posedge ref_clk) disable iff (rst)
		(cmp_access_en && cmp_acc.rd && cmp_acc.sel) |=> (cmp_rdata == $past(cmp_q[1])))
		else $error("permitted read of compare 1 wrong");
	a_by1_flag: assert property (@(posedge ref_clk) disable iff (rst)
		(s_detect ##0 (cond_sel == 2'h2 && fetch_addr == cmp_q[1] &&
		fetch_addr != cmp_q[0])) |=> match_by1)
		else $error("decision bit wrong for compare 1");
	a_by0_flag: assert property (@(posedge ref_clk) disable iff (rst)
		(s_detect ##0 (cond_sel == 2'h2 && fetch_addr == cmp_q[0]))
		|=> !match_by1)
		else $error("decision bit wrong for compare 0");
	a_push_addr: assert property (@(posedge ref_clk) disable iff (rst)
		s_detect |=> (push_frame.pc == $past(fetch.pc) &&
		push_frame.bank == $past(fetch.bank)))
		else $error("pushed address not the matched one");
	a_push_psw: assert property (@(posedge ref_clk) disable iff (rst)
		s_detect |=> (push_valid && push_frame.psw == $past(processor_status_word)))
		else $error("pushed status word not the one at the match");
endmodule // famd_detector

// ===== core/famd_pkg.sv
// package for the fetch address match detector
// assumes a 24-bit fetch address: 8-bit bank above a 16-bit program counter
package famd_pkg;

	// ------------------------------------------------------------
	// widths and reset values
	// ------------------------------------------------------------
	localparam int          BANK_W      = 8;
	localparam int          PC_W        = 16;
	localparam int          ADDR_W      = BANK_W + PC_W;
	localparam logic [23:0] CMP_RST     = 24'h000000;
	localparam logic [1:0]  COND_RST    = 2'h0;
	localparam logic [BANK_W-1:0] VEC_BANK = 8'h00; // bank of the detection vector

	// ------------------------------------------------------------
	// detection conditions
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		COND_MATCH0   = 2'b00,
		COND_MATCH1   = 2'b01,
		COND_MATCH_EI = 2'b10,
		COND_OUT_AREA = 2'b11
	} famd_cond_type;

	// controller states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_PUSH  = 2'b01,
		ST_VECT  = 2'b10
	} famd_state_type;

	// fetch request from the cpu
	typedef struct packed {
		logic                 valid;
		logic [BANK_W-1:0]    bank;
		logic [PC_W-1:0]      pc;
	} famd_fetch_type;

	// software access to a compare register
	typedef struct packed {
		logic                 rd;
		logic                 wr;
		logic                 sel;   // 0: compare 0, 1: compare 1
		logic [ADDR_W-1:0]    wdata;
	} famd_cmp_acc_type;

	// frame pushed on the stack at detection
	typedef struct packed {
		logic [BANK_W-1:0]    bank;
		logic [PC_W-1:0]      pc;
		logic [15:0]          psw;
	} famd_frame_type;

endpackage

// ===== sim/famd_cpu_model.sv
// cpu fetch path model facing the fetch address match detector
// assumes it shares ref_clk and rst with the detector
module famd_cpu_model (
	// clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     rst,
	// bench request
	input  wire logic                     go,
	input  wire logic [23:0]              addr,
	// detector side
	input  wire logic                     fetch_ready,
	input  wire logic                     fetch_suppress,
	input  wire logic                     push_valid,
	input  wire famd_pkg::famd_frame_type push_frame,
	output famd_pkg::famd_fetch_type      fetch,
	// observations
	output logic                          seen_supp,
	output famd_pkg::famd_frame_type      frame_q,
	output logic [7:0]                    nmi_cnt
);
	timeunit 1ns;
	timeprecision 1ps;

	// fetch held until taken; released address lines show the inverse
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fetch     <= '0;
			seen_supp <= 1'b0;
			frame_q   <= '0;
			nmi_cnt   <= 8'h00;
		end else begin
			if (go)
				fetch <= {1'b1, addr};
			else if (fetch.valid && fetch_ready)
				fetch <= {1'b0, ~fetch[23:0]};
			if (fetch.valid && fetch_ready)
				seen_supp <= fetch_suppress;
			if (push_valid) begin
				frame_q <= push_frame;
				nmi_cnt <= nmi_cnt + 8'h01;
			end
		end
	end
endmodule // famd_cpu_model

// ===== sim/famd_detector_test.sv
// self-checking bench for the fetch address match detector
// assumes famd_pkg and the cpu model are compiled first
module famd_detector_test;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [23:0] C0  = 24'h123400;
	localparam logic [23:0] C1  = 24'h125600;
	localparam logic [15:0] PSW = 16'h5a3c;
	logic [23:0] tbl [6] = '{C0, C1, C0 - 24'h1, C1 + 24'h1, 24'h133400, 24'h124000};
	logic                       ref_clk = 1'b0;
	logic                       rst = 1'b1;
	logic                       detect_en = 1'b0;
	logic [1:0]                 cond_sel = 2'h0;
	logic                       cmp_access_en = 1'b0;
	logic [15:0]                processor_status_word = PSW;
	famd_pkg::famd_cmp_acc_type cmp_acc = '0;
	famd_pkg::famd_fetch_type   fetch;
	famd_pkg::famd_frame_type   push_frame, frame_q;
	logic [23:0]                cmp_rdata;
	logic [23:0]                addr = 24'h000000;
	logic                       go = 1'b0;
	logic                       fetch_ready, fetch_suppress, nmi_req, push_valid;
	logic                       match_by1, seen_supp;
	logic [7:0]                 nmi_cnt;
	int                         err_count = 0;
	int                         samples_checked = 0;
	int                         cycles = 0;
	int                         nmi_seen = 0;
	int                         busy_seen = 0;

	// clock
	always #4 ref_clk = ~ref_clk;

	famd_detector dut_u (.ref_clk, .rst, .detect_en, .cond_sel, .cmp_access_en, .cmp_acc,
		.cmp_rdata, .fetch, .processor_status_word, .fetch_ready, .fetch_suppress,
		.nmi_req, .push_valid, .push_frame, .match_by1);
	famd_cpu_model cpu_u (.ref_clk, .rst, .go, .addr, .fetch_ready, .fetch_suppress,
		.push_valid, .push_frame, .fetch, .seen_supp, .frame_q, .nmi_cnt);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic tally_and_finish;
		if (err_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// expected firing per condition, unsigned over bank and pc
	function automatic logic hit_exp(input int c, input logic [23:0] a);
		case (c)
			0: return a == C0;
			1: return a == C1;
			2: return a == C0 || a == C1;
			default: return a < C0 || a > C1;
		endcase
	endfunction

	// enable raised a cycle ahead of the access and dropped right after it
	task automatic acc_cmp(input logic en, input logic rd, input logic sel,
		input logic [23:0] v);
		@(posedge ref_clk);
		cmp_access_en <= en;
		@(posedge ref_clk);
		cmp_acc <= {rd, ~rd, sel, v};
		@(posedge ref_clk);
		cmp_access_en <= 1'b0;
		cmp_acc.rd <= 1'b0;
		cmp_acc.wr <= 1'b0;
		@(posedge ref_clk);
		if (rd)
			chk("cmp_rdata", 40'(v), 40'(cmp_rdata));
	endtask

	// one fetch; status word varies with the address so a stuck push shows
	task automatic do_fetch(input logic [23:0] a, input logic exp);
		logic [7:0] n0;
		int         r0;
		int         b0;
		n0 = nmi_cnt;
		r0 = nmi_seen;
		b0 = busy_seen;
		@(posedge ref_clk);
		go <= 1'b1;
		addr <= a;
		processor_status_word <= a[15:0] ^ PSW;
		@(posedge ref_clk);
		go <= 1'b0;
		repeat (5) @(posedge ref_clk);
		chk("nmi count", 40'(exp), 40'(nmi_cnt - n0));
		chk("nmi_req pulses", 40'(exp), 40'(nmi_seen - r0));
		chk("fetch_ready low cycles", 40'(2 * exp), 40'(busy_seen - b0));
		chk("fetch_suppress", 40'(exp), 40'(seen_supp));
		if (exp)
			chk("push_frame", {a, a[15:0] ^ PSW}, frame_q);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		acc_cmp(1'b1, 1'b0, 1'b0, C0);
		acc_cmp(1'b1, 1'b0, 1'b1, C1);
		acc_cmp(1'b0, 1'b0, 1'b0, 24'hffffff);
		acc_cmp(1'b1, 1'b1, 1'b1, C1);
		acc_cmp(1'b0, 1'b1, 1'b0, C1);
		acc_cmp(1'b1, 1'b1, 1'b0, C0);
	endtask

	task automatic t_conds;
		logic e;
		detect_en <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			cond_sel <= 2'(c);
			for (int i = 0; i < 6; i++) begin
				e = hit_exp(c, tbl[i]);
				do_fetch(tbl[i], e);
				if (c == 2 && e)
					chk("match_by1", 40'(tbl[i] == C1), 40'(match_by1));
			end
		end
	endtask

	// decision bit falls back to compare 0, then the routine resumes past the match
	task automatic t_resume;
		cond_sel <= 2'h2;
		do_fetch(C0, 1'b1);
		chk("match_by1", 40'h0, 40'(match_by1));
		do_fetch({frame_q.bank, frame_q.pc} + 24'h1, 1'b0);
	endtask

	task automatic t_disable;
		detect_en <= 1'b0;
		cond_sel <= 2'h0;
		do_fetch(C0, 1'b0);
	endtask

	// mid-run reset: outputs go idle, first accesses right after release
	task automatic t_reset;
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk("cmp_rdata", 40'h0, 40'(cmp_rdata));
		chk("push_frame", 40'h0, push_frame);
		chk("fetch_ready", 40'h1, 40'(fetch_ready));
		rst <= 1'b0;
		acc_cmp(1'b1, 1'b1, 1'b0, 24'h000000);
		acc_cmp(1'b1, 1'b0, 1'b0, C1);
		acc_cmp(1'b1, 1'b1, 1'b0, C1);
	endtask

	// hang guard and counters of request pulses and busy cycles
	always @(posedge ref_clk) begin
		cycles++;
		nmi_seen  <= nmi_seen + int'(nmi_req);
		busy_seen <= busy_seen + int'(!fetch_ready);
		if (cycles == 2000) begin
			err_count++;
			tally_and_finish;
		end
	end

	// main sequence
	initial begin
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		t_regs;
		t_conds;
		t_resume;
		t_disable;
		t_reset;
		tally_and_finish;
	end
endmodule // famd_detector_test
